// ---- hw/uoe_event_flags.sv ----
// Design decisions made here: the Wishbone register port and the address map.
`timescale 1ns/100ps
`include "uoe_params.svh"
module uoe_event_flags #(
  parameter int unsigned MS_CYCLES = `UOE_MS_CYC
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // USB side pins
  input wire logic dp_i,
  input wire logic dm_i,
  input wire logic id_i,
  input wire logic vbus_i,
  input wire logic sess_end_i,
  input wire logic sess_valid_i,
  input wire logic suspend_i,
  // Interrupt and status
  output logic irq_o,
  output logic [1:0] line_state_o
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  localparam int NIN = 6;
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] syn;
  assign raw_in = {sess_valid_i, sess_end_i, vbus_i, id_i, dm_i, dp_i};

  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_sync
      uoe_sync u_sync (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .d_i(raw_in[gi]),
        .q_o(syn[gi])
      );
    end
  endgenerate

  logic s_dp, s_dm, s_id, s_vbus, s_send, s_sval;
  assign {s_sval, s_send, s_vbus, s_id, s_dm, s_dp} = syn;

  // ----------------------------------------
  // Previous-value capture for edge detection
  // ----------------------------------------
  logic [NIN-1:0] prev_ff;
  logic [1:0] prime_ff;

  // Capture levels; hold off edges until the synchronisers have filled
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev_ff <= '0;
      prime_ff <= 2'h0;
    end else begin
      prev_ff <= syn;
      if (prime_ff != 2'h3) begin
        prime_ff <= prime_ff + 2'h1;
      end
    end
  end

  // A pin already high at reset gives no false change
  logic [NIN-1:0] chg;
  assign chg = (prime_ff == 2'h3) ? (syn ^ prev_ff) : '0;

  // ----------------------------------------
  // 1 ms timer
  // ----------------------------------------
  logic ms_tick;
  uoe_ms_timer #(
    .PERIOD(MS_CYCLES)
  ) u_timer (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .tick_o(ms_tick)
  );

  // ----------------------------------------
  // Line state stability monitor
  // ----------------------------------------
  localparam int unsigned LW = $clog2(MS_CYCLES + 1);
  localparam logic [LW-1:0] L_LAST = LW'(MS_CYCLES - 1);
  logic [LW-1:0] stab_cnt_ff;
  logic [1:0] settled_ff;
  logic stab_done_ff;
  logic line_evt;
  logic [1:0] cur_line;
  assign cur_line = {s_dm, s_dp};
  assign line_evt = (stab_cnt_ff == L_LAST) && !stab_done_ff
                    && (cur_line != settled_ff);

  // Count cycles of unchanged line state
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stab_cnt_ff <= '0;
    end else if (chg[1] || chg[0]) begin
      stab_cnt_ff <= '0;
    end else if (stab_cnt_ff != L_LAST) begin
      stab_cnt_ff <= stab_cnt_ff + LW'(1);
    end
  end

  // Settle point used once until the next line change
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stab_done_ff <= 1'b0;
    end else if (chg[1] || chg[0]) begin
      stab_done_ff <= 1'b0;
    end else if (stab_cnt_ff == L_LAST) begin
      stab_done_ff <= 1'b1;
    end
  end

  // Remember last settled state
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      settled_ff <= 2'h0;
    end else if (line_evt) begin
      settled_ff <= cur_line;
    end
  end

  // ----------------------------------------
  // Event vector
  // ----------------------------------------
  logic wake_evt;
  logic sesv_evt;
  logic [7:0] evt;
  // Wake: DP, DM, ID or VBUS pin activity while suspended
  assign wake_evt = suspend_i && (|chg[3:0]);
  // VBUS indication falling below session end
  assign sesv_evt = chg[4] && s_send;

  always_comb begin
    evt = 8'h00;
    evt[`UOE_BIT_ID] = chg[2];
    evt[`UOE_BIT_TMR] = ms_tick;
    evt[`UOE_BIT_LINE] = line_evt;
    evt[`UOE_BIT_ACT] = wake_evt;
    evt[`UOE_BIT_SESV] = sesv_evt;
    evt[`UOE_BIT_BVBUS] = chg[4];
    evt[`UOE_BIT_AVBUS] = chg[5];
  end

  // ----------------------------------------
  // Bus cycle tracking
  // ----------------------------------------
  uoe_pkg::uoe_bus_t bus_st_ff;
  uoe_pkg::uoe_bus_t nxt_bus_st;

  // One answer per request, then back to idle
  always_comb begin
    nxt_bus_st = bus_st_ff;
    unique case (bus_st_ff)
      uoe_pkg::UOE_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          nxt_bus_st = uoe_pkg::UOE_ACK;
        end
      end
      uoe_pkg::UOE_ACK: begin
        nxt_bus_st = uoe_pkg::UOE_IDLE;
      end
    endcase
  end

  // Bus state register
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bus_st_ff <= uoe_pkg::UOE_IDLE;
    end else begin
      bus_st_ff <= nxt_bus_st;
    end
  end

  // ----------------------------------------
  // Wishbone decode
  // ----------------------------------------
  logic req;
  logic hit_stat;
  logic hit_mask;
  logic wr_stat;
  logic wr_mask;
  logic rd_stat;
  logic rd_mask;
  // Take a request only while no answer is pending
  assign req = wb_cyc_i && wb_stb_i && (bus_st_ff == uoe_pkg::UOE_IDLE);
  assign hit_stat = (wb_adr_i == `UOE_STATUS_OFS);
  assign hit_mask = (wb_adr_i == `UOE_MASK_OFS);
  assign wr_stat = req && wb_we_i && hit_stat && wb_sel_i[0];
  assign wr_mask = req && wb_we_i && hit_mask && wb_sel_i[0];
  assign rd_stat = req && !wb_we_i && hit_stat;
  assign rd_mask = req && !wb_we_i && hit_mask;

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  logic [7:0] status_ff;
  logic [7:0] nxt_status;
  logic [7:0] clr;
  assign clr = wr_stat ? wb_dat_i[7:0] : 8'h00;

  // Set wins over clear; only hardware sets
  always_comb begin
    nxt_status = (status_ff & ~clr) | evt;
    nxt_status = nxt_status & `UOE_FLAG_MASK;
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      status_ff <= `UOE_STATUS_RST;
    end else begin
      status_ff <= nxt_status;
    end
  end

  // ----------------------------------------
  // Interrupt mask
  // ----------------------------------------
  logic [7:0] mask_ff;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mask_ff <= `UOE_MASK_RST;
    end else if (wr_mask) begin
      mask_ff <= wb_dat_i[7:0] & `UOE_FLAG_MASK;
    end
  end

  // Registered level interrupt from the next status value
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(nxt_status & mask_ff);
    end
  end

  // ----------------------------------------
  // Bus answer
  // ----------------------------------------
  // Acknowledge for mapped registers
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req && (hit_stat || hit_mask);
    end
  end

  // Error for unmapped addresses
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wb_err_o <= 1'b0;
    end else begin
      wb_err_o <= req && !(hit_stat || hit_mask);
    end
  end

  // Read data, zero outside an answered read
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd_stat) begin
      wb_dat_o <= {24'h00_0000, status_ff};
    end else if (rd_mask) begin
      wb_dat_o <= {24'h00_0000, mask_ff};
    end else begin
      wb_dat_o <= 32'h0000_0000;
    end
  end

  // Settled line state view
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      line_state_o <= 2'h0;
    end else begin
      line_state_o <= settled_ff;
    end
  end

endmodule : uoe_event_flags

// ---- hw/uoe_ms_timer.sv ----
`timescale 1ns/100ps
// Free-running period timer, one-cycle tick at expiry
module uoe_ms_timer #(
  parameter int unsigned PERIOD = 20000
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  output logic tick_o
);
  localparam int unsigned W = $clog2(PERIOD + 1);
  localparam logic [W-1:0] LAST = W'(PERIOD - 1);
  logic [W-1:0] cnt_ff;

  // Count and wrap
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_ff <= '0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= (cnt_ff == LAST);
      cnt_ff <= (cnt_ff == LAST) ? '0 : cnt_ff + W'(1);
    end
  end
endmodule : uoe_ms_timer

// ---- hw/uoe_params.svh ----
`ifndef UOE_PARAMS_SVH
`define UOE_PARAMS_SVH

// Register byte offsets
`define UOE_STATUS_OFS 4'h0
`define UOE_MASK_OFS 4'h4
// Event bit positions
`define UOE_BIT_ID 7
`define UOE_BIT_TMR 6
`define UOE_BIT_LINE 5
`define UOE_BIT_ACT 4
`define UOE_BIT_SESV 3
`define UOE_BIT_BVBUS 2
`define UOE_BIT_AVBUS 0
// Implemented flag bits
`define UOE_FLAG_MASK 8'hFD
`define UOE_STATUS_RST 8'h00
`define UOE_MASK_RST 8'h00
// Timing
`define UOE_CLK_HZ 20000000
`define UOE_MS_US 1000
`define UOE_MS_CYC ((`UOE_CLK_HZ / 1000000) * `UOE_MS_US)

`endif

// ---- hw/uoe_pkg.sv ----
package uoe_pkg;
  // Bus cycle state
  typedef enum logic [0:0] {
    UOE_IDLE = 1'b0,
    UOE_ACK = 1'b1
  } uoe_bus_t;
endpackage : uoe_pkg

// ---- hw/uoe_sync.sv ----
`timescale 1ns/100ps
// Two-flop synchroniser for one level
module uoe_sync (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_ff;

  // Double register
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_ff <= 1'b0;
      q_o <= 1'b0;
    end else begin
      meta_ff <= d_i;
      q_o <= meta_ff;
    end
  end
endmodule : uoe_sync

// ---- verification/testbench.sv ----
`timescale 1ns/100ps
// ----------
// Bench
// ----------
module testbench;
  localparam int MS = 40;
  logic clock_i, rstn_i, wb_cyc_i, wb_stb_i, wb_we_i, suspend_i, e;
  logic wb_ack_o, wb_err_o, irq_o;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [1:0] line_state_o;
  logic [5:0] tog, pins;
  wire logic dp_i, dm_i, id_i, vbus_i, sess_end_i, sess_valid_i;
  int fails, tests_run, cyc_n;
  assign {sess_valid_i, sess_end_i, vbus_i, id_i, dm_i, dp_i} = pins;
  uoe_event_flags #(.MS_CYCLES(MS)) uoe_event_flags_inst (.clock_i, .rstn_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .wb_err_o, .dp_i, .dm_i, .id_i, .vbus_i,
    .sess_end_i, .sess_valid_i, .suspend_i, .irq_o, .line_state_o);
  uoe_usb_model uoe_usb_model_inst (.clock_i, .rstn_i, .tog_i(tog),
    .pins_o(pins));
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One classic bus cycle, waits for the answer
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clock_i);
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    q = wb_dat_o;
    e = wb_err_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clock_i);
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [31:0] m,
                    input logic [31:0] x);
    bus(a, 1'b0, 32'h0);
    chk(q & m, x);
  endtask : rd
  // Flip lines for one edge, then wait
  task automatic pulse(input logic [5:0] t, input int w);
    tog <= t;
    @(posedge clock_i);
    tog <= 6'h00;
    repeat (w) @(posedge clock_i);
  endtask : pulse
  task automatic finish_test;
    $display("Counts: fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  // Clock
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  // Hang guard
  always @(posedge clock_i) begin
    cyc_n++;
    if (cyc_n == 2000) begin
      fails++;
      finish_test();
    end
  end
  // Main sequence
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, suspend_i, rstn_i} = 5'h00;
    {wb_adr_i, wb_sel_i, wb_dat_i, tog} = {8'h0F, 32'h0, 6'h0};
    {fails, tests_run, cyc_n} = '0;
    repeat (3) @(posedge clock_i);
    rstn_i <= 1'b1;
    @(posedge clock_i);
    rd(4'h0, 32'hFFFFFFFF, 32'h0);
    bus(4'h8, 1'b0, 32'h0);
    chk({31'h0, e}, 32'h1);
    bus(4'h4, 1'b1, 32'hFFFFFFFF);
    rd(4'h4, 32'hFFFFFFFF, 32'hFD);
    $display("Test registers done");
    pulse(6'h34, 8);
    rd(4'h0, 32'hFFFFFFBF, 32'h8D);
    chk({31'h0, irq_o}, 32'h1);
    bus(4'h0, 1'b1, 32'h84);
    rd(4'h0, 32'hBF, 32'h09);
    wb_sel_i <= 4'hE;
    bus(4'h0, 1'b1, 32'hFF);
    wb_sel_i <= 4'hF;
    rd(4'h0, 32'hBF, 32'h09);
    bus(4'h0, 1'b1, 32'hFF);
    pulse(6'h10, 8);
    rd(4'h0, 32'h0C, 32'h04);
    $display("Test events done");
    bus(4'h0, 1'b1, 32'hFF);
    repeat (MS + 6) @(posedge clock_i);
    rd(4'h0, 32'h40, 32'h40);
    pulse(6'h01, MS + 10);
    rd(4'h0, 32'h30, 32'h20);
    chk({30'h0, line_state_o}, 32'h1);
    suspend_i <= 1'b1;
    pulse(6'h08, 8);
    repeat (20) @(posedge clock_i);
    rd(4'h0, 32'hBF, 32'h30);
    bus(4'h4, 1'b1, 32'h0);
    @(posedge clock_i);
    chk({31'h0, irq_o}, 32'h0);
    $display("Test timer line activity done");
    finish_test();
  end
endmodule : testbench

// ---- verification/uoe_event_flags_assertions.sv ----
`timescale 1ns/100ps
// ----------
// Flag checker
// ----------
module uoe_event_flags_chk #(
  parameter int unsigned MS_CYCLES = 20000
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic id_i,
  input wire logic sess_valid_i,
  input wire logic irq_o,
  input wire logic [1:0] line_state_o
);
  localparam int unsigned TMX = MS_CYCLES + 4;
  logic [7:0] mask_ff;
  logic take;
  int unsigned lo_cnt;
  // Request taken this edge
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  // Shadow of the mask register
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) mask_ff <= 8'h00;
    else if (take && wb_we_i && wb_adr_i == 4'h4 && wb_sel_i[0])
      mask_ff <= wb_dat_i[7:0];
  end
  // Cycles the interrupt stays low while the timer flag is enabled
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) lo_cnt <= 0;
    else if (irq_o || !mask_ff[6]) lo_cnt <= 0;
    else lo_cnt <= lo_cnt + 1;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  property p_rst; disable iff (1'b0) !rstn_i |-> !irq_o && !wb_ack_o;
  endproperty
  property p_ack; take |=> wb_ack_o || wb_err_o; endproperty
  property p_err; take && wb_adr_i != 4'h0 && wb_adr_i != 4'h4
    |=> wb_err_o && !wb_ack_o; endproperty
  property p_hi; wb_ack_o |-> wb_dat_o[31:8] == 24'h0 && !wb_dat_o[1];
  endproperty
  property p_id; $changed(id_i) && mask_ff[7] |-> ##[1:6] irq_o;
  endproperty
  property p_vs; $changed(sess_valid_i) && mask_ff[0] |-> ##[1:6] irq_o;
  endproperty
  property p_tmr; lo_cnt <= TMX; endproperty
  property p_stk; irq_o && !wb_stb_i |=> irq_o; endproperty
  a_rst: assert property (p_rst) else $error("active in reset");
  a_ack: assert property (p_ack) else $error("no answer");
  a_err: assert property (p_err) else $error("no error answer");
  a_hi: assert property (p_hi) else $error("unused bits set");
  a_id: assert property (p_id) else $error("id change lost");
  a_vs: assert property (p_vs) else $error("valid change lost");
  a_tmr: assert property (p_tmr) else $error("no timer flag");
  a_stk: assert property (p_stk) else $error("flag not sticky");
  c_err: cover property (wb_err_o);
  c_irq: cover property ($rose(irq_o));
  c_line: cover property ($changed(line_state_o));
endmodule : uoe_event_flags_chk

bind uoe_event_flags uoe_event_flags_chk #(.MS_CYCLES(MS_CYCLES)) chk_inst (
  .clock_i, .rstn_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .id_i, .sess_valid_i, .irq_o,
  .line_state_o);

// ---- verification/uoe_usb_model.sv ----
`timescale 1ns/100ps
// Sense lines of the far side
module uoe_usb_model (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic [5:0] tog_i,
  output logic [5:0] pins_o
);
  // Each request bit flips one line just after the edge
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) pins_o <= 6'h00;
    else pins_o <= pins_o ^ tog_i;
  end
endmodule : uoe_usb_model
